// *** scs_pkg.sv ***
// shared constants and types for the snapshot capture and sync control block
package scs_pkg;
	// register indices; the bus byte address is four times the index
	localparam logic [9:0] IDX_CTRL_A = 10'h008;
	localparam logic [9:0] IDX_CTRL_B = 10'h009;
	localparam logic [9:0] IDX_START = 10'h00A;
	localparam logic [9:0] IDX_PULSE = 10'h00B;
	// capture memory windows, one index per word
	localparam logic [2:0] MEM_A_TOP = 3'h4;
	localparam logic [2:0] MEM_B_TOP = 3'h5;

	// half control fields
	localparam int SRC_LSB = 0;
	localparam int DEC_LSB = 2;
	localparam int LAG_LSB = 4;
	localparam int INH_BIT = 8;
	localparam int BYTE_BIT = 9;
	localparam logic [15:0] HALF_MASK = 16'h03FF;
	localparam logic [15:0] HALF_RESET = 16'h0000;

	// start control fields
	localparam int TRIG_LSB = 0;
	localparam int RDW_LSB = 2;
	localparam int ARM_BIT = 4;
	localparam int DONE_A_BIT = 5;
	localparam int DONE_B_BIT = 6;
	localparam int SYNC_SEL_LSB = 8;
	localparam int IGNORE_BIT = 10;
	localparam logic [15:0] START_MASK = 16'h077F;
	localparam logic [15:0] START_RESET = 16'h0000;

	// timing counts in clocks, and the depth of each capture half in words
	localparam int SYNC_DELAY = 4;
	localparam int LAG_BLOCK_LOG2 = 7;
	localparam int HALF_WORDS = 128;

	typedef enum logic [1:0] {
		SCS_IDLE = 2'b00,
		SCS_LAG = 2'b01,
		SCS_RUN = 2'b11
	} scs_phase_t;

	typedef struct packed {
		scs_phase_t phase;
		logic [12:0] lag;
		logic [1:0] dec;
		logic [7:0] pos;
	} scs_half_t;
endpackage

// *** scs_capture_mem.sv ***
// one capture memory half: byte-enabled write port, registered read port
`timescale 1ns/10ps
`default_nettype none
module scs_capture_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [AW-1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we && be[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		if (we && be[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// *** scs_top.sv ***
// snapshot capture controller with sync output control and AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
module scs_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [11:0] chan_a_input,
	input wire logic [11:0] chan_b_input,
	input wire logic [15:0] chan_a_output,
	input wire logic [15:0] chan_b_output,
	input wire logic capture_strobe_pin,
	input wire logic sync_in_pin,
	input wire logic terminal_count,
	output logic sync_out_pin,
	output logic one_pulse_pin,
	output logic sync_counter_load
);
	typedef struct packed {
		logic [1:0][15:0] ctrl;
		logic [15:0] start;
		scs_pkg::scs_half_t [1:0] half;
		logic [scs_pkg::SYNC_DELAY-2:0] sync_dly;
		logic sync_out;
		logic one_pulse;
		logic counter_load;
		logic dp_write;
		logic [9:0] dp_idx;
		logic [1:0] rd_cnt;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} scs_state_t;

	scs_state_t s_q;
	scs_state_t s_d;

	logic sync_g;
	logic trig_cond;
	logic trig;
	logic accept;
	logic [15:0] read_val;
	logic [1:0] done_set;
	logic [1:0] mem_we;
	logic [1:0][1:0] mem_be;
	logic [1:0][6:0] mem_waddr;
	logic [1:0][15:0] mem_wdata;
	logic [1:0][15:0] mem_rdata;

	// inputs are left-justified so the byte store keeps their top eight bits
	function automatic logic [15:0] pick_source(input logic [1:0] sel, input logic [11:0] ib,
			input logic [11:0] ia, input logic [15:0] oa, input logic [15:0] ob);
		case (sel)
			2'd0: pick_source = {ib, 4'h0};
			2'd1: pick_source = {ia, 4'h0};
			2'd2: pick_source = oa;
			default: pick_source = ob;
		endcase
	endfunction

	function automatic logic [12:0] lag_cycles(input logic [3:0] lag, input logic [1:0] dec);
		logic [12:0] base;
		base = 13'({lag, 7'h00});
		lag_cycles = 13'(base * 13'(dec)) + base;
	endfunction

	function automatic logic [15:0] shape_read(input logic [15:0] w, input logic [1:0] mode);
		case (mode)
			2'd1: shape_read = {{8{w[7]}}, w[7:0]};
			2'd3: shape_read = {{8{w[15]}}, w[15:8]};
			default: shape_read = w;
		endcase
	endfunction

	assign sync_g = sync_in_pin && !s_q.start[scs_pkg::IGNORE_BIT];
	assign accept = hsel && htrans[1] && hready;

	always_comb begin
		case (s_q.start[scs_pkg::TRIG_LSB +: 2])
			2'd0: trig_cond = 1'b1;
			2'd1: trig_cond = capture_strobe_pin;
			2'd2: trig_cond = sync_g;
			default: trig_cond = terminal_count;
		endcase
	end
	assign trig = s_q.start[scs_pkg::ARM_BIT] && trig_cond;

	// one generate serves both halves so they stay identical
	for (genvar g = 0; g < 2; g++) begin : g_half
		logic byte_mode;
		logic [15:0] sample;
		assign byte_mode = s_q.ctrl[g][scs_pkg::BYTE_BIT];
		// sources passed as arguments so the assign follows every sample change
		assign sample = pick_source(s_q.ctrl[g][scs_pkg::SRC_LSB +: 2], chan_b_input,
			chan_a_input, chan_a_output, chan_b_output);
		assign mem_we[g] = (s_q.half[g].phase == scs_pkg::SCS_RUN) && (s_q.half[g].dec == 2'd0);
		assign mem_waddr[g] = s_q.half[g].pos[6:0];
		assign mem_be[g] = !byte_mode ? 2'b11 : (s_q.half[g].pos[7] ? 2'b10 : 2'b01);
		assign mem_wdata[g] = byte_mode ? {sample[15:8], sample[15:8]} : sample;

		scs_capture_mem #(
			.DEPTH(scs_pkg::HALF_WORDS),
			.AW(7)
		) u_mem (
			.clk(hclk),
			.we(mem_we[g]),
			.be(mem_be[g]),
			.waddr(mem_waddr[g]),
			.wdata(mem_wdata[g]),
			.raddr(s_q.dp_idx[6:0]),
			.rdata(mem_rdata[g])
		);
	end

	always_comb begin
		case (s_q.dp_idx)
			scs_pkg::IDX_CTRL_A: read_val = s_q.ctrl[0] & scs_pkg::HALF_MASK;
			scs_pkg::IDX_CTRL_B: read_val = s_q.ctrl[1] & scs_pkg::HALF_MASK;
			scs_pkg::IDX_START: read_val = s_q.start & scs_pkg::START_MASK;
			default: begin
				if (s_q.dp_idx[9:7] == scs_pkg::MEM_A_TOP) begin
					read_val = shape_read(mem_rdata[0], s_q.start[scs_pkg::RDW_LSB +: 2]);
				end else if (s_q.dp_idx[9:7] == scs_pkg::MEM_B_TOP) begin
					read_val = shape_read(mem_rdata[1], s_q.start[scs_pkg::RDW_LSB +: 2]);
				end else begin
					read_val = 16'h0000; // pulse address and unmapped space
				end
			end
		endcase
	end

	always_comb begin
		logic [1:0] rate;
		logic last;
		logic [12:0] lagc;
		rate = 2'd0;
		last = 1'b0;
		lagc = 13'h0000;
		s_d = s_q;
		done_set = 2'b00;
		s_d.one_pulse = 1'b0;
		s_d.hresp = 1'b0;
		s_d.sync_dly = {s_q.sync_dly[scs_pkg::SYNC_DELAY-3:0], sync_g};
		s_d.counter_load = sync_g;
		if (trig) begin
			s_d.start[scs_pkg::ARM_BIT] = 1'b0;
		end

		for (int i = 0; i < 2; i++) begin
			rate = s_q.ctrl[i][scs_pkg::DEC_LSB +: 2];
			last = s_q.ctrl[i][scs_pkg::BYTE_BIT] ? (s_q.half[i].pos == 8'hFF)
				: (s_q.half[i].pos == 8'h7F);
			case (s_q.half[i].phase)
				scs_pkg::SCS_LAG: begin
					if (s_q.half[i].lag == 13'h0001) begin
						s_d.half[i].phase = scs_pkg::SCS_RUN;
						s_d.half[i].dec = 2'd0;
						s_d.half[i].pos = 8'h00;
					end else begin
						s_d.half[i].lag = s_q.half[i].lag - 13'h0001;
					end
				end
				scs_pkg::SCS_RUN: begin
					if (s_q.half[i].dec == 2'd0) begin
						s_d.half[i].dec = rate;
						s_d.half[i].pos = s_q.half[i].pos + 8'h01;
						if (last) begin
							s_d.half[i].phase = scs_pkg::SCS_IDLE;
							done_set[i] = 1'b1;
						end
					end else begin
						s_d.half[i].dec = s_q.half[i].dec - 2'd1;
					end
				end
				default: begin
					s_d.half[i].phase = scs_pkg::SCS_IDLE;
				end
			endcase
			// a new trigger restarts a half that is not inhibited
			if (trig && !s_q.ctrl[i][scs_pkg::INH_BIT]) begin
				lagc = lag_cycles(s_q.ctrl[i][scs_pkg::LAG_LSB +: 4], rate);
				s_d.half[i].dec = 2'd0;
				s_d.half[i].pos = 8'h00;
				s_d.half[i].lag = lagc;
				s_d.half[i].phase = (lagc == 13'h0000) ? scs_pkg::SCS_RUN : scs_pkg::SCS_LAG;
			end
		end

		// read data phase: one cycle for the memory register, one for hrdata
		if (s_q.rd_cnt == 2'd1) begin
			s_d.rd_cnt = 2'd2;
		end else if (s_q.rd_cnt == 2'd2) begin
			s_d.rd_cnt = 2'd0;
			s_d.hrdata = {16'h0000, read_val};
			s_d.hreadyout = 1'b1;
		end

		if (s_q.dp_write) begin
			case (s_q.dp_idx)
				scs_pkg::IDX_CTRL_A: s_d.ctrl[0] = hwdata[15:0] & scs_pkg::HALF_MASK;
				scs_pkg::IDX_CTRL_B: s_d.ctrl[1] = hwdata[15:0] & scs_pkg::HALF_MASK;
				scs_pkg::IDX_START: begin
					s_d.start = hwdata[15:0] & scs_pkg::START_MASK;
					// done flags only fall by writing zero; a one leaves them as they were
					s_d.start[scs_pkg::DONE_A_BIT] = s_q.start[scs_pkg::DONE_A_BIT]
						&& hwdata[scs_pkg::DONE_A_BIT];
					s_d.start[scs_pkg::DONE_B_BIT] = s_q.start[scs_pkg::DONE_B_BIT]
						&& hwdata[scs_pkg::DONE_B_BIT];
				end
				scs_pkg::IDX_PULSE: s_d.one_pulse = 1'b1;
				default: begin
				end
			endcase
		end
		// completion beats a simultaneous clear
		if (done_set[0]) begin
			s_d.start[scs_pkg::DONE_A_BIT] = 1'b1;
		end
		if (done_set[1]) begin
			s_d.start[scs_pkg::DONE_B_BIT] = 1'b1;
		end

		case (s_q.start[scs_pkg::SYNC_SEL_LSB +: 2])
			2'd0: s_d.sync_out = s_q.sync_dly[scs_pkg::SYNC_DELAY-2];
			2'd1: s_d.sync_out = terminal_count;
			2'd2: s_d.sync_out = s_d.one_pulse;
			default: s_d.sync_out = 1'b0;
		endcase

		s_d.dp_write = accept && hwrite;
		if (accept) begin
			s_d.dp_idx = haddr[11:2];
			if (!hwrite) begin
				s_d.rd_cnt = 2'd1;
				s_d.hreadyout = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.ctrl <= {scs_pkg::HALF_RESET, scs_pkg::HALF_RESET};
			s_q.start <= scs_pkg::START_RESET;
			s_q.hreadyout <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = s_q.hreadyout;
	assign hresp = s_q.hresp;
	assign hrdata = s_q.hrdata;
	assign sync_out_pin = s_q.sync_out;
	assign one_pulse_pin = s_q.one_pulse;
	assign sync_counter_load = s_q.counter_load;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic wr_start;
	assign wr_start = s_q.dp_write && (s_q.dp_idx == scs_pkg::IDX_START);

	chk_arm_clear: assert property (trig && !wr_start |=> !s_q.start[scs_pkg::ARM_BIT])
		else $error("arm bit not cleared by trigger");
	chk_done_a_sticky: assert property (s_q.start[scs_pkg::DONE_A_BIT] && !wr_start
		|=> s_q.start[scs_pkg::DONE_A_BIT])
		else $error("A done flag dropped without a write");
	chk_done_b_set: assert property (s_q.half[1].phase == scs_pkg::SCS_RUN && done_set[1]
		|=> s_q.start[scs_pkg::DONE_B_BIT] && s_q.half[1].phase == scs_pkg::SCS_IDLE)
		else $error("B done flag not raised at completion");
	chk_lag_end: assert property (s_q.half[0].phase == scs_pkg::SCS_LAG
		&& s_q.half[0].lag == 13'h0001 && !trig |=> mem_we[0])
		else $error("A half did not start recording after its lag");
	chk_inhibit_hold: assert property (s_q.half[1].phase == scs_pkg::SCS_IDLE
		&& s_q.ctrl[1][scs_pkg::INH_BIT] |=> s_q.half[1].phase == scs_pkg::SCS_IDLE)
		else $error("inhibited B half started");
	chk_quarter_rate: assert property (mem_we[0] && s_q.ctrl[0][scs_pkg::DEC_LSB +: 2] == 2'd3
		&& !trig |=> !mem_we[0] [*3])
		else $error("quarter rate stored too often");
	chk_pulse_write: assert property (s_q.dp_write && s_q.dp_idx == scs_pkg::IDX_PULSE
		|=> one_pulse_pin)
		else $error("pulse missing after pulse write");
	chk_sync_delay: assert property (s_q.start[scs_pkg::SYNC_SEL_LSB +: 2] == 2'd0 [*5]
		|-> sync_out_pin == $past(sync_g, 4))
		else $error("sync output not delayed by four clocks");
	chk_sync_ignore: assert property (s_q.start[scs_pkg::IGNORE_BIT] |=> !sync_counter_load)
		else $error("sync input passed while ignored");
	chk_word_read: assert property (s_q.rd_cnt == 2'd2
		&& s_q.dp_idx[9:7] == scs_pkg::MEM_A_TOP && !s_q.start[scs_pkg::RDW_LSB]
		|=> hrdata == {16'h0000, $past(mem_rdata[0])})
		else $error("word readback differs from memory");
	chk_byte_sign: assert property (s_q.rd_cnt == 2'd2
		&& s_q.dp_idx[9:7] == scs_pkg::MEM_B_TOP && s_q.start[scs_pkg::RDW_LSB]
		|=> hrdata[15:8] == {8{hrdata[7]}})
		else $error("byte readback not sign-extended");
	chk_arm_fall: assert property ($fell(s_q.start[scs_pkg::ARM_BIT])
		|-> $past(trig) || $past(wr_start))
		else $error("arm bit fell without trigger or write");
	chk_pulse_single: assert property (one_pulse_pin
		&& !(s_q.dp_write && s_q.dp_idx == scs_pkg::IDX_PULSE) |=> !one_pulse_pin)
		else $error("pulse longer than one cycle");
	chk_done_rise: assert property ($rose(s_q.start[scs_pkg::DONE_A_BIT])
		|-> $past(done_set[0]) && (s_q.half[0].phase == scs_pkg::SCS_IDLE || $past(trig)))
		else $error("A done flag rose before the last sample");
	chk_pos_step: assert property (mem_we[0] && !trig
		|=> s_q.half[0].pos == $past(s_q.half[0].pos) + 8'h01)
		else $error("A half address did not step by one");
	chk_ctrl_unused: assert property (s_q.rd_cnt == 2'd2
		&& s_q.dp_idx == scs_pkg::IDX_CTRL_A |=> hrdata[31:10] == 22'h00_0000)
		else $error("unused control bits read nonzero");
	chk_sync_tc: assert property (s_q.start[scs_pkg::SYNC_SEL_LSB +: 2] == 2'd1
		|=> sync_out_pin == $past(terminal_count))
		else $error("sync output does not follow terminal count");
	chk_trig_start: assert property (trig && !s_q.ctrl[0][scs_pkg::INH_BIT]
		|=> s_q.half[0].phase != scs_pkg::SCS_IDLE)
		else $error("A half did not start on its trigger");

	cov_done_a: cover property ($rose(s_q.start[scs_pkg::DONE_A_BIT]));
	cov_byte_done: cover property (done_set[1] && s_q.ctrl[1][scs_pkg::BYTE_BIT]);
	cov_mem_read: cover property (s_q.rd_cnt == 2'd2 && s_q.dp_idx[9:7] == scs_pkg::MEM_A_TOP);
	cov_pulse: cover property (one_pulse_pin);
endmodule
`default_nettype wire

// *** scs_host_model.sv ***
// host processor model: single-word AHB-Lite master for the control port
`timescale 1ns/10ps
`default_nettype none
module scs_host_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// each phase is held until hready is sampled high; no wait count assumed
	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [15:0] wd,
			output logic [15:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata[15:0];
	endtask
endmodule
`default_nettype wire

// *** snapshot_capture_and_sync_control_tb_top.sv ***
// self-checking bench for the snapshot capture and sync control block
`timescale 1ns/10ps
`default_nettype none
module snapshot_capture_and_sync_control_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hresp;
	logic sync_out_pin, one_pulse_pin, sync_counter_load;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, pins;
	logic [15:0] ramp, v, v0, w;
	logic [7:0] b0;
	int err_count, n_tests, cyc, n_pulse, n_diff, d_out, d_load;
	localparam logic [9:0] RA = scs_pkg::IDX_CTRL_A;
	localparam logic [9:0] RB = scs_pkg::IDX_CTRL_B;
	localparam logic [9:0] RS = scs_pkg::IDX_START;
	localparam logic [9:0] MA = {scs_pkg::MEM_A_TOP, 7'h00};
	localparam logic [9:0] MB = {scs_pkg::MEM_B_TOP, 7'h00};

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial ramp = 16'h0000;
	// free-running ramp makes every stored sample predictable from the first
	always @(posedge hclk) ramp <= ramp + 16'h0001;
	always @(posedge hclk) begin
		cyc++;
		if (one_pulse_pin === 1'b1) n_pulse++;
		if (sync_out_pin !== one_pulse_pin) n_diff++;
		if (cyc > 20000) begin
			err_count++;
			$display("timeout at %0t", $time);
			finish_test();
		end
	end

	scs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .chan_a_input(ramp[11:0]),
		.chan_b_input({ramp[8:1], 4'h0}), .chan_a_output(ramp), .chan_b_output(~ramp),
		.capture_strobe_pin(pins[0]), .sync_in_pin(pins[1]), .terminal_count(pins[2]),
		.sync_out_pin(sync_out_pin), .one_pulse_pin(one_pulse_pin),
		.sync_counter_load(sync_counter_load));
	scs_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		logic [15:0] x;
		host.xfer(a, 1'b1, d, x);
	endtask
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		host.xfer(a, 1'b0, 16'h0000, d);
		chk(hrdata[31:16] | 16'(hresp), 16'h0000);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_done(input int b);
		do rd(RS, v); while (v[b] !== 1'b1);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// delays are counted in sampling edges, the pin's own capture edge included
	task automatic probe(input int p, input int wo, input int wl);
		d_out = 99;
		d_load = 99;
		@(posedge hclk);
		pins <= 3'(1 << p);
		for (int k = 1; k < 10; k++) begin
			@(posedge hclk);
			pins <= 3'h0;
			if (sync_out_pin === 1'b1 && d_out == 99) d_out = k;
			if (sync_counter_load === 1'b1 && d_load == 99) d_load = k;
		end
		chk(16'(d_out), 16'(wo));
		if (p == 1) chk(16'(d_load), 16'(wl));
	endtask
	function automatic logic [15:0] exp_b(input int m, input int i);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = b0 + 8'(i);
		hi = b0 + 8'(i + 128);
		case (m)
			1: exp_b = {{8{lo[7]}}, lo};
			3: exp_b = {{8{hi[7]}}, hi};
			default: exp_b = {hi, lo};
		endcase
	endfunction

	initial begin
		hresetn = 1'b0;
		pins = 3'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		rd(RB, v);
		chk(v, 16'h0000);
		wr(RA, 16'hFFFF);
		rd(RA, v);
		chk(v, 16'h03FF);
		wr(RS, 16'hFFFF);
		rd(RS, v);
		chk(v, 16'h071F);
		wr(RS, 16'h0000);
		rd(scs_pkg::IDX_PULSE, v);
		chk(v, 16'h0000);
		rd(10'h3FF, v);
		chk(v, 16'h0000);
		$display("test registers done");
		wr(RB, 16'h0100);
		wr(RA, 16'h001E);
		wr(RS, 16'h0010);
		w = ramp;
		wait_done(5);
		chk(v & 16'h0050, 16'h0000);
		rd(MA, v0);
		chk((v0 - w - 16'h0200) & 16'hFFF8, 16'h0000);
		for (int i = 1; i < 128; i++) begin
			rd(MA + 10'(i), v);
			chk(v, v0 + 16'(4 * i));
		end
		wr(RS, 16'h0000);
		rd(RS, v);
		chk(v, 16'h0000);
		$display("test word capture done");
		wr(RA, 16'h0100);
		wr(RB, 16'h0204);
		wr(RS, 16'h0010);
		wait_done(6);
		chk(v & 16'h0030, 16'h0000);
		wr(RS, 16'h0000);
		rd(RS, v);
		chk(v, 16'h0000);
		rd(MB, v);
		b0 = v[7:0];
		for (int m = 0; m < 4; m++) begin
			wr(RS, 16'(m << 2));
			for (int i = 0; i < 128; i++) begin
				rd(MB + 10'(i), v);
				chk(v, exp_b(m, i));
			end
		end
		$display("test byte capture done");
		wr(RA, 16'h0000);
		wr(RB, 16'h0100);
		for (int t = 1; t < 4; t++) begin
			logic [15:0] step;
			step = (t == 1) ? 16'h0010 : ((t == 2) ? 16'hFFFF : 16'h0001);
			wr(RA, (t == 1) ? 16'h0001 : ((t == 2) ? 16'h0003 : 16'h0002));
			wr(RS, 16'(t) | 16'h0010);
			repeat (8) @(posedge hclk);
			rd(RS, v);
			chk(v & 16'h0010, 16'h0010);
			@(posedge hclk);
			pins <= 3'(1 << (t - 1));
			@(posedge hclk);
			pins <= 3'h0;
			rd(RS, v);
			chk(v & 16'h0010, 16'h0000);
			wait_done(5);
			rd(MA, v0);
			rd(MA + 10'd1, v);
			chk(v - v0, step);
			rd(MA + 10'd127, v);
			chk(v - v0, 16'(127 * step));
		end
		$display("test triggers done");
		wr(RS, 16'h0000);
		probe(1, 5, 2);
		wr(RS, 16'h0100);
		probe(2, 2, 0);
		wr(RS, 16'h0300);
		probe(2, 99, 0);
		wr(RS, 16'h0400);
		probe(1, 99, 99);
		wr(RS, 16'h0200);
		repeat (4) @(negedge hclk);
		n_pulse = 0;
		n_diff = 0;
		wr(scs_pkg::IDX_PULSE, 16'h5A5A);
		repeat (6) @(posedge hclk);
		chk(16'(n_pulse), 16'h0001);
		chk(16'(n_diff), 16'h0000);
		$display("test sync and pulse done");
		finish_test();
	end
endmodule
`default_nettype wire
